// ### include/link_ctrl_pkg.sv
// link_ctrl_pkg: offsets, field positions, reset values and carrier types
// of the link operation control block.
// assumes one 50 MHz clock domain; the receive side delivers quadlets
// already classified by packet kind on the same clock.
package link_ctrl_pkg;

    // register byte offsets on the apb
    localparam logic [7:0] node_address_offset = 8'h04;
    localparam logic [7:0] link_operation_control_offset = 8'h08;
    localparam logic [7:0] link_status_offset = 8'h0C;

    // reset values
    localparam logic [31:0] link_operation_control_reset = 32'h00000000;
    localparam logic [5:0] node_number_reset = 6'h00;

    // node-address register field
    localparam int node_number_lsb = 10;

    // control register bit positions
    localparam int node_id_valid_bit = 0;
    localparam int receive_self_identification_bit = 1;
    localparam int force_busy_ack_bit = 2;
    localparam int receive_all_isochronous_bit = 3;
    localparam int receive_cycle_start_packets_bit = 4;
    localparam int async_transmit_enable_bit = 5;
    localparam int async_receive_enable_bit = 6;
    localparam int isochronous_receive_enable_bit = 8;

    // control bits that software may store
    localparam logic [31:0] control_write_mask = 32'h0000017F;

    // status register bit positions
    localparam int status_buffer_valid_bit = 0;
    localparam int status_buffer_full_bit = 1;
    localparam int status_pair_pending_bit = 2;

    // node address that is always accepted
    localparam logic [5:0] broadcast_node = 6'h3F;

    // status tags stored with self-identification data
    localparam logic [3:0] self_id_good_tag = 4'h1;
    localparam logic [3:0] self_id_bad_tag = 4'hD;
    // tag stored with every other quadlet
    localparam logic [3:0] plain_tag = 4'h0;

    // kinds of packet arriving from the physical layer
    typedef enum logic [2:0] {
        kind_async,
        kind_isochronous,
        kind_cycle_start,
        kind_self_id,
        kind_link_on,
        kind_phy_config
    } packet_kind_t;

    // one received quadlet with its framing
    typedef struct packed {
        logic [31:0] data;
        packet_kind_t kind;
        logic [5:0] dest_node;
        logic first;
        logic last;
    } rx_quadlet_t;

    // one entry of the general receive fifo
    typedef struct packed {
        logic [3:0] tag;
        logic [31:0] data;
    } fifo_word_t;

endpackage

// ### verilog/link_operation_control.sv
// link_operation_control: control register, receive acceptance, ack
// choice and the two-entry buffer in front of the general receive fifo.
// assumes the receive quadlet stream, bus reset pulse and the fifo drain
// all run on clock; software reaches the registers over apb.
`timescale 1ns/100ps

module link_operation_control
(
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive quadlets from the physical-layer side
    input wire logic rx_valid,
    input wire link_ctrl_pkg::rx_quadlet_t rx_quadlet,
    output logic rx_ready,
    input wire logic bus_reset,
    // ack choice for a received async packet
    output logic ack_busy,
    output logic ack_complete,
    // transmitter gates
    output logic async_tx_allowed,
    // general receive fifo side
    output logic fifo_valid,
    output link_ctrl_pkg::fifo_word_t fifo_word,
    input wire logic fifo_ready
);

    logic [31:0] link_operation_control;
    logic [5:0] node_number;
    logic pkt_store;
    logic pkt_first_only;
    logic pkt_ack_busy;
    logic pkt_ack_done;
    logic pair_pending;
    logic [31:0] pair_first;
    logic skid_valid;
    link_ctrl_pkg::fifo_word_t skid_word;

    // control bit views
    wire node_id_valid =
        link_operation_control[link_ctrl_pkg::node_id_valid_bit];
    wire receive_self_identification =
        link_operation_control[link_ctrl_pkg::receive_self_identification_bit];
    wire force_busy_ack =
        link_operation_control[link_ctrl_pkg::force_busy_ack_bit];
    wire receive_all_isochronous =
        link_operation_control[link_ctrl_pkg::receive_all_isochronous_bit];
    wire receive_cycle_start_packets =
        link_operation_control[link_ctrl_pkg::receive_cycle_start_packets_bit];
    wire async_transmit_enable =
        link_operation_control[link_ctrl_pkg::async_transmit_enable_bit];
    wire async_receive_enable =
        link_operation_control[link_ctrl_pkg::async_receive_enable_bit];
    wire isochronous_receive_enable =
        link_operation_control[link_ctrl_pkg::isochronous_receive_enable_bit];

    // apb decode
    wire apb_setup = psel && !penable;
    wire apb_done = psel && penable && pready;
    wire hit_node = paddr == link_ctrl_pkg::node_address_offset;
    wire hit_control = paddr == link_ctrl_pkg::link_operation_control_offset;
    wire hit_status = paddr == link_ctrl_pkg::link_status_offset;
    wire hit_any = hit_node || hit_control || hit_status;
    wire write_node = apb_done && pwrite && hit_node;
    wire write_control = apb_done && pwrite && hit_control;

    // read data mux
    wire [31:0] status_word = {29'h00000000, pair_pending, skid_valid,
        fifo_valid};
    wire [31:0] node_word = {16'h0000, node_number, 10'h000};
    wire [31:0] read_word = hit_control ? link_operation_control :
        hit_node ? node_word :
        hit_status ? status_word : 32'h00000000;

    // next control value: software write, then bus reset clears the two async enables
    wire [31:0] written_control = write_control ?
        (pwdata & link_ctrl_pkg::control_write_mask) : link_operation_control;
    wire [31:0] bus_reset_clear =
        (32'h00000001 << link_ctrl_pkg::async_transmit_enable_bit) |
        (32'h00000001 << link_ctrl_pkg::async_receive_enable_bit);
    wire [31:0] next_link_operation_control = bus_reset ?
        (written_control & ~bus_reset_clear) : written_control;

    // destination matching of the arriving quadlet
    wire rx_take = rx_valid && rx_ready;
    wire is_broadcast =
        rx_quadlet.dest_node == link_ctrl_pkg::broadcast_node;
    wire is_own = node_id_valid &&
        rx_quadlet.dest_node == node_number;
    wire kind_async = rx_quadlet.kind == link_ctrl_pkg::kind_async;
    wire kind_iso = rx_quadlet.kind == link_ctrl_pkg::kind_isochronous;
    wire kind_cycle = rx_quadlet.kind == link_ctrl_pkg::kind_cycle_start;
    wire kind_sid = rx_quadlet.kind == link_ctrl_pkg::kind_self_id;
    wire kind_phy_short = rx_quadlet.kind == link_ctrl_pkg::kind_link_on ||
        rx_quadlet.kind == link_ctrl_pkg::kind_phy_config;

    // async acceptance and busy decision at the first quadlet
    wire async_for_us = kind_async && async_receive_enable &&
        (is_broadcast || is_own);
    wire async_addressed = async_for_us && !is_broadcast;
    wire async_busy = async_addressed &&
        (force_busy_ack || skid_valid);
    wire iso_accept = kind_iso && isochronous_receive_enable &&
        receive_all_isochronous;
    wire cycle_accept = kind_cycle && receive_cycle_start_packets;
    wire sid_accept = kind_sid && receive_self_identification;
    wire short_accept = kind_phy_short && receive_self_identification;
    wire first_store = (async_for_us && !async_busy) || iso_accept ||
        cycle_accept || short_accept;

    // per-quadlet store decision
    wire store_now = rx_quadlet.first ? first_store :
        (pkt_store && !pkt_first_only);
    wire sid_pair_end = sid_accept && pair_pending;
    wire sid_good = rx_quadlet.data == ~pair_first;
    wire [3:0] sid_tag = sid_good ? link_ctrl_pkg::self_id_good_tag :
        link_ctrl_pkg::self_id_bad_tag;
    wire push = rx_take && (kind_sid ? sid_pair_end : store_now);
    link_ctrl_pkg::fifo_word_t push_word;
    assign push_word = kind_sid ? {sid_tag, pair_first} :
        {link_ctrl_pkg::plain_tag, rx_quadlet.data};

    // ack outcome at packet end
    wire busy_end = rx_quadlet.first ? async_busy : pkt_ack_busy;
    wire done_end = rx_quadlet.first ?
        (async_addressed && !async_busy) : pkt_ack_done;
    wire packet_end = rx_take && rx_quadlet.last;

    // two-entry buffer moves
    wire out_free = !fifo_valid || fifo_ready;

    // apb response, ready in the first access cycle after setup, no wait state
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup && !hit_any;
            prdata <= (apb_setup && !pwrite) ? read_word : 32'h00000000;
        end
    end

    // software registers
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            link_operation_control <=
                link_ctrl_pkg::link_operation_control_reset;
            node_number <= link_ctrl_pkg::node_number_reset;
        end
        else
        begin
            link_operation_control <= next_link_operation_control;
            if (write_node)
            begin
                node_number <= pwdata[link_ctrl_pkg::node_number_lsb +: 6];
            end
        end
    end

    // transmit gate follows the enable
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            async_tx_allowed <= 1'b0;
        end
        else
        begin
            async_tx_allowed <=
                next_link_operation_control
                    [link_ctrl_pkg::async_transmit_enable_bit];
        end
    end

    // packet state held from the first quadlet
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pkt_store <= 1'b0;
            pkt_first_only <= 1'b0;
            pkt_ack_busy <= 1'b0;
            pkt_ack_done <= 1'b0;
        end
        else if (rx_take && rx_quadlet.first)
        begin
            pkt_store <= first_store;
            pkt_first_only <= short_accept;
            pkt_ack_busy <= async_busy;
            pkt_ack_done <= async_addressed && !async_busy;
        end
    end

    // self-id pairing across the whole initialization packet
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pair_pending <= 1'b0;
            pair_first <= 32'h00000000;
        end
        else if (bus_reset)
        begin
            pair_pending <= 1'b0;
        end
        else if (rx_take && sid_accept)
        begin
            pair_pending <= !pair_pending;
            if (!pair_pending)
            begin
                pair_first <= rx_quadlet.data;
            end
        end
    end

    // ack pulses, one cycle at packet end
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_busy <= 1'b0;
            ack_complete <= 1'b0;
        end
        else
        begin
            ack_busy <= packet_end && kind_async && busy_end;
            ack_complete <= packet_end && kind_async && done_end;
        end
    end

    // output stage of the two-entry buffer
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            fifo_valid <= 1'b0;
            fifo_word <= '0;
        end
        else if (out_free)
        begin
            fifo_valid <= skid_valid || push;
            if (skid_valid)
            begin
                fifo_word <= skid_word;
            end
            else if (push)
            begin
                fifo_word <= push_word;
            end
        end
    end

    // spare stage catches a word while the drain stalls
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            skid_valid <= 1'b0;
            skid_word <= '0;
        end
        else if (out_free)
        begin
            skid_valid <= 1'b0;
        end
        else if (push)
        begin
            skid_valid <= 1'b1;
            skid_word <= push_word;
        end
    end

    // source may send only while the spare stage is empty
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_ready <= 1'b0;
        end
        else
        begin
            rx_ready <= out_free || !(skid_valid || push);
        end
    end

endmodule // link_operation_control

// ### sim/link_ctrl_checker.sv
// link_ctrl_checker: port relations of link_operation_control
// assumes it is bound to the top module, one clock, nrst active low
`timescale 1ns/100ps
module link_ctrl_checker
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire link_ctrl_pkg::rx_quadlet_t rx_quadlet,
    input wire logic rx_ready,
    input wire logic bus_reset,
    input wire logic ack_busy,
    input wire logic ack_complete,
    input wire logic async_tx_allowed,
    input wire logic fifo_valid,
    input wire link_ctrl_pkg::fifo_word_t fifo_word,
    input wire logic fifo_ready
);
    // decoded events
    wire mapped = paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0C;
    wire ctl_wr = psel && penable && pready && pwrite && paddr == 8'h08;
    wire bcast = rx_valid && rx_ready && rx_quadlet.first
        && rx_quadlet.last && rx_quadlet.dest_node == 6'h3F
        && rx_quadlet.kind == link_ctrl_pkg::kind_async;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_status;
        pready |-> pslverr == !mapped;
    endproperty
    a_status: assert property (p_status) else $error("bad slverr");
    property p_read;
        pready && !pwrite && paddr == 8'h08
            |-> prdata[31:9] == 23'h0 && !prdata[7];
    endproperty
    a_read: assert property (p_read) else $error("spare bits set");
    property p_tx_write;
        ctl_wr && !bus_reset |=> async_tx_allowed == $past(pwdata[5]);
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx gate");
    property p_bus_reset;
        bus_reset |=> !async_tx_allowed;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("tx kept");
    property p_bcast;
        bcast |=> !ack_busy && !ack_complete;
    endproperty
    a_bcast: assert property (p_bcast) else $error("bcast ack");
    property p_ack_excl;
        ack_busy |-> !ack_complete;
    endproperty
    a_ack_excl: assert property (p_ack_excl) else $error("two acks");
    property p_hold;
        fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_word);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost");
endmodule // link_ctrl_checker

// ### sim/phy_rx_model.sv
// phy_rx_model: physical-layer side offering received quadlets
// assumes the link takes a quadlet at an edge with valid and ready high
`timescale 1ns/100ps
module phy_rx_model
(
    input wire logic clock,
    input wire logic rx_ready,
    output logic rx_valid,
    output link_ctrl_pkg::rx_quadlet_t rx_quadlet
);
    // idle line at time zero
    initial
    begin
        rx_valid = 1'b0;
        rx_quadlet = '0;
    end
    // offer one quadlet, hold it until taken, then scramble the data
    task automatic send(input link_ctrl_pkg::rx_quadlet_t q);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_quadlet <= q;
        do
        begin
            @(posedge clock);
        end
        while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        rx_quadlet.data <= ~q.data; // stale data never looks valid
    endtask
endmodule // phy_rx_model

// ### sim/tb_link_control_register.sv
// tb_link_control_register: random and corner tests of the control block
// assumes the design package is compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    miscompares++; $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module tb_link_control_register;
    localparam link_ctrl_pkg::packet_kind_t ka = link_ctrl_pkg::kind_async;
    localparam link_ctrl_pkg::packet_kind_t ks = link_ctrl_pkg::kind_self_id;
    localparam link_ctrl_pkg::packet_kind_t kc =
        link_ctrl_pkg::kind_cycle_start;
    logic clock, nrst, psel, penable, pwrite, bus_reset, fifo_ready, stall;
    logic pready, pslverr, rx_valid, rx_ready, err;
    logic ack_busy, ack_complete, async_tx_allowed, fifo_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    link_ctrl_pkg::rx_quadlet_t rx_quadlet;
    link_ctrl_pkg::fifo_word_t fifo_word, g, e;
    link_ctrl_pkg::fifo_word_t got[$], exp[$];
    int miscompares, n_compared, n_busy, n_cmpl, b0, c0;
    // acceptance table: control value, destination, stored, busy, complete
    logic [8:0] ctl[10] = '{9'h041, 9'h041, 9'h041, 9'h040, 9'h045,
        9'h001, 9'h008, 9'h108, 9'h010, 9'h000};
    logic [5:0] dst[10] = '{6'h05, 6'h07, 6'h3F, 6'h05, 6'h05,
        6'h05, 6'h3F, 6'h3F, 6'h3F, 6'h3F};
    logic [9:0] keep = 10'b0110000101;
    logic [9:0] busy = 10'b0000010000;
    logic [9:0] cmpl = 10'b0000000001;
    link_operation_control dut (.clock, .nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_quadlet,
        .rx_ready, .bus_reset, .ack_busy, .ack_complete, .async_tx_allowed,
        .fifo_valid, .fifo_word, .fifo_ready);
    phy_rx_model phy (.clock, .rx_ready, .rx_valid, .rx_quadlet);
    always #10 clock = ~clock;
    // random drain, word collection and ack counting
    always @(posedge clock)
    begin
        fifo_ready <= stall ? 1'b0 : 1'($urandom_range(1));
        if (fifo_valid === 1'b1 && fifo_ready === 1'b1)
            got.push_back(fifo_word);
        if (ack_busy === 1'b1) n_busy++;
        if (ack_complete === 1'b1) n_cmpl++;
    end
    // one apb transfer, read data and error kept in rd and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // offer one quadlet and note what should be stored
    task put(input link_ctrl_pkg::packet_kind_t k, input logic [5:0] dn,
        input logic [31:0] d, input logic [1:0] fl, input logic st,
        input logic [3:0] tag);
        phy.send('{d, k, dn, fl[1], fl[0]});
        if (st) exp.push_back('{tag, d});
    endtask
    // compare stored words in order
    task check_fifo;
        repeat (40) @(posedge clock);
        `CHK(got.size(), exp.size())
        while (exp.size() > 0 && got.size() > 0)
        begin
            g = got.pop_front();
            e = exp.pop_front();
            `CHK(g, e)
        end
        got.delete();
        exp.delete();
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_sim();
    end
    initial
    begin
        {clock, nrst, psel, penable, pwrite, bus_reset, fifo_ready} = '0;
        {stall, paddr, pwdata, miscompares, n_compared, n_busy, n_cmpl} = '0;
        void'($urandom(9));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, link_ctrl_pkg::link_operation_control_reset)
        v = $urandom;
        apb(1'b1, 8'h08, v);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, v & link_ctrl_pkg::control_write_mask)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h04, 32'h5 << 10);
        $display("registers done");
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, 8'h08, {23'h0, ctl[i]});
            b0 = n_busy;
            c0 = n_cmpl;
            put(i < 6 ? ka : i < 8 ? link_ctrl_pkg::kind_isochronous : kc,
                dst[i], $urandom, 2'b11, keep[i], 4'h0);
            check_fifo();
            `CHK(n_busy - b0, int'(busy[i]))
            `CHK(n_cmpl - c0, int'(cmpl[i]))
        end
        $display("acceptance done");
        apb(1'b1, 8'h08, 32'h2);
        v = $urandom;
        put(ks, 6'h3F, v, 2'b10, 1'b1, 4'h1);
        put(ks, 6'h3F, ~v, 2'b00, 1'b0, 4'h0);
        put(ks, 6'h3F, v + 1, 2'b00, 1'b1, 4'hD);
        put(ks, 6'h3F, v, 2'b01, 1'b0, 4'h0);
        put(link_ctrl_pkg::kind_link_on, 6'h3F, v, 2'b10, 1'b1, 4'h0);
        put(link_ctrl_pkg::kind_phy_config, 6'h3F, ~v, 2'b01, 1'b0, 4'h0);
        check_fifo();
        $display("self id done");
        apb(1'b1, 8'h08, 32'h10);
        stall <= 1'b1;
        fork
            repeat (3) put(kc, 6'h3F, $urandom, 2'b11, 1'b1, 4'h0);
            begin
                repeat (20) @(posedge clock);
                `CHK(rx_ready, 1'b0)
                stall <= 1'b0;
            end
        join
        check_fifo();
        $display("stall done");
        apb(1'b1, 8'h08, 32'h60);
        @(posedge clock);
        `CHK(async_tx_allowed, 1'b1)
        bus_reset <= 1'b1;
        @(posedge clock);
        bus_reset <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(async_tx_allowed, 1'b0)
        $display("bus reset done");
        end_sim();
    end
endmodule // tb_link_control_register
bind link_operation_control link_ctrl_checker chk (.clock, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_valid, .rx_quadlet, .rx_ready, .bus_reset, .ack_busy, .ack_complete,
    .async_tx_allowed, .fifo_valid, .fifo_word, .fifo_ready);
